// file: shared/ldma_consts.vh
// Purpose: Constants for the LAN DMA dual-port memory arbiter
// Assumes: 100 MHz system clock; the arbiter logic runs on a half-rate enable
// Notes:   Header holds definitions only
`ifndef LDMA_CONSTS_VH
`define LDMA_CONSTS_VH

// Arbiter state codes
`define LDMA_ST_IDLE      3'h0
`define LDMA_ST_MEM       3'h1
`define LDMA_ST_IO        3'h2
`define LDMA_ST_HOLD      3'h3
`define LDMA_ST_HOLD_MEM  3'h4
`define LDMA_ST_LAN_OWN   3'h5
`define LDMA_STATE_W      3

// Clock divide: arbiter runs at half the oscillator rate
`define LDMA_DIV_RATIO    2
// Address windows
`define LDMA_MEM_WIN_LSB  14
`define LDMA_IO_WIN_LSB   7
// I/O offsets inside the controller window
`define LDMA_IO_OFF_DATA  7'h00
`define LDMA_IO_OFF_HIGH  7'h02
`define LDMA_IO_OFF_STAT  7'h04
// Burst shape
`define LDMA_BURST_WORDS  8
`define LDMA_WORD_BITS    16
`define LDMA_BYTE_BITS    8

`endif

// file: src/ldma_clk_div.v
// Purpose: One-cycle enable pulse at a divided rate
// Assumes: Single system clock, synchronous active-low reset
// Notes:   Used as the arbiter's half-rate tick
`include "ldma_consts.vh"
module ldma_clk_div #(
  parameter RATIO = `LDMA_DIV_RATIO
) (
  input  wire clock_in,
  input  wire rstn_in,
  output reg  tick_out
);
  reg [7:0] count;

  // Divided tick for the arbiter clock domain
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end else if (count == RATIO[7:0] - 8'h01) begin
      count    <= 8'h00;
      tick_out <= 1'b1;
    end else begin
      count    <= count + 8'h01;
      tick_out <= 1'b0;
    end
  end
endmodule // ldma_clk_div

// file: src/ldma_sync_reg.v
// Purpose: Clocked input register ahead of the arbiter
// Assumes: Inputs synchronous to clock_in
// Notes:   Loads only on the arbiter tick, as a prelatch would
module ldma_sync_reg #(
  parameter WIDTH = 4,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
  input  wire             clock_in,
  input  wire             rstn_in,
  input  wire             tick_in,
  input  wire [WIDTH-1:0] d_in,
  output reg  [WIDTH-1:0] q_out
);
  // Idle level is the inactive (high) level of each request
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      q_out <= RESET_VAL;
    end else if (tick_in) begin
      q_out <= d_in;
    end
  end
endmodule // ldma_sync_reg

// file: src/ldma_arbiter.v
// Purpose: Dual-port buffer memory arbiter between a CPU bus and a LAN DMA controller
// Assumes: All inputs synchronous to clock_in; CPU bus reset drives rstn_in
// Notes:   Encoder and media logic live outside; lan_rst_n_out forwards the reset
`include "ldma_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module ldma_arbiter #(
  parameter ADDR_W = 20,
  parameter IOA_W  = 16
) (
  input  wire              clock_in,
  input  wire              rstn_in,
  // CPU bus
  input  wire [ADDR_W-1:0] cpu_mem_addr_in,
  input  wire              cpu_mem_rd_n_in,
  input  wire              cpu_mem_wr_n_in,
  input  wire              cpu_bhe_n_in,
  input  wire [IOA_W-1:0]  cpu_io_addr_in,
  input  wire              cpu_io_rd_n_in,
  input  wire              cpu_io_wr_n_in,
  input  wire [15:0]       cpu_data_in,
  input  wire              host_8bit_in,
  input  wire [ADDR_W-1:0] mem_base_in,
  input  wire [IOA_W-1:0]  io_base_in,
  output reg  [15:0]       cpu_data_out,
  output wire              cpu_ready_out,
  // LAN controller
  input  wire              dma_hold_request_n_in,
  input  wire              lan_bus_state_five_in,
  input  wire              lan_wr_n_in,
  input  wire              lan_bhe_n_in,
  input  wire              lan_a0_in,
  input  wire [15:0]       lan_rd_data_in,
  output reg               dma_hold_grant_out,
  output reg               lan_ctrl_select_n_out,
  output reg               lan_io_wr_out,
  output reg  [15:0]       lan_wr_data_out,
  output wire              lan_rst_n_out,
  output wire              encoder_rst_n_out,
  // Shared RAM
  output reg               memory_grant_n_out,
  output reg               lan_mem_owner_out,
  output wire              ram_we_high_n_out,
  output wire              ram_we_low_n_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function in_window;
    input [ADDR_W-1:0] addr;
    input [ADDR_W-1:0] base;
    input integer      lsb;
    integer k;
    begin
      in_window = 1'b1;
      for (k = lsb; k < ADDR_W; k = k + 1) begin
        if (addr[k] != base[k]) begin
          in_window = 1'b0;
        end
      end
    end
  endfunction

  wire mem_hit;
  wire io_hit;
  wire [6:0] io_off;
  assign mem_hit = in_window(cpu_mem_addr_in, mem_base_in, `LDMA_MEM_WIN_LSB);
  assign io_hit  = in_window({{(ADDR_W-IOA_W){1'b0}}, cpu_io_addr_in},
                             {{(ADDR_W-IOA_W){1'b0}}, io_base_in}, `LDMA_IO_WIN_LSB);
  assign io_off  = cpu_io_addr_in[`LDMA_IO_WIN_LSB-1:0];

  wire stat_acc;
  wire high_acc;
  assign stat_acc = io_hit && (io_off == `LDMA_IO_OFF_STAT);
  assign high_acc = host_8bit_in && io_hit && (io_off == `LDMA_IO_OFF_HIGH);

  // Raw active-low requests; status and upper-byte accesses bypass the controller
  wire memory_request_raw_n;
  wire io_request_raw_n;
  wire io_strobe;
  assign io_strobe = !cpu_io_rd_n_in || !cpu_io_wr_n_in;
  assign memory_request_raw_n = !(mem_hit && (!cpu_mem_rd_n_in || !cpu_mem_wr_n_in));
  assign io_request_raw_n = !(io_hit && !stat_acc && !high_acc && io_strobe);

  ////////////////////////////////////////////////////////////////////////////
  // Half-rate tick and input register
  wire tick;
  ldma_clk_div #(.RATIO(`LDMA_DIV_RATIO)) u_div (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .tick_out (tick)
  );

  wire [3:0] req_q;
  ldma_sync_reg #(.WIDTH(4), .RESET_VAL(4'hb)) u_sync (
    .clock_in (clock_in),
    .rstn_in  (rstn_in),
    .tick_in  (tick),
    .d_in     ({dma_hold_request_n_in, lan_bus_state_five_in, io_request_raw_n, memory_request_raw_n}),
    .q_out    (req_q)
  );
  wire dma_hold_request_n;
  wire bus_state_five;
  wire io_request_n;
  wire memory_request_n;
  assign dma_hold_request_n = req_q[3];
  assign bus_state_five     = req_q[2];
  assign io_request_n       = req_q[1];
  assign memory_request_n   = req_q[0];

  assign lan_rst_n_out     = rstn_in;
  assign encoder_rst_n_out = rstn_in;

  ////////////////////////////////////////////////////////////////////////////
  // Arbiter state machine
  reg [`LDMA_STATE_W-1:0] state;
  reg [`LDMA_STATE_W-1:0] next_state;

  always @* begin
    next_state = state;
    case (state)
      `LDMA_ST_IDLE: begin
        if (!dma_hold_request_n) begin
          next_state = `LDMA_ST_HOLD;
        end else if (!io_request_n) begin
          next_state = `LDMA_ST_IO;
        end else if (!memory_request_n) begin
          next_state = `LDMA_ST_MEM;
        end
      end
      `LDMA_ST_MEM: begin
        if (memory_request_n) begin
          next_state = `LDMA_ST_IDLE;
        end
      end
      `LDMA_ST_IO: begin
        if (io_request_n) begin
          next_state = `LDMA_ST_IDLE;
        end
      end
      `LDMA_ST_HOLD: begin
        if (dma_hold_request_n) begin
          next_state = `LDMA_ST_IDLE;
        end else if (bus_state_five) begin
          next_state = `LDMA_ST_LAN_OWN;
        end else if (!memory_request_n) begin
          next_state = `LDMA_ST_HOLD_MEM;
        end
      end
      `LDMA_ST_HOLD_MEM: begin
        // CPU cycle finishes before the LAN takes the RAM
        if (memory_request_n) begin
          next_state = `LDMA_ST_HOLD;
        end
      end
      `LDMA_ST_LAN_OWN: begin
        // No preemption: RAM stays with the LAN until the burst ends
        if (dma_hold_request_n) begin
          next_state = `LDMA_ST_IDLE;
        end
      end
      default: begin
        next_state = `LDMA_ST_IDLE;
      end
    endcase
  end

  always @(posedge clock_in) begin
    if (!rstn_in) begin
      state <= `LDMA_ST_IDLE;
    end else if (tick) begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered grant outputs
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      dma_hold_grant_out    <= 1'b0;
      lan_ctrl_select_n_out <= 1'b1;
      memory_grant_n_out    <= 1'b1;
      lan_mem_owner_out     <= 1'b0;
    end else begin
      dma_hold_grant_out    <= (state == `LDMA_ST_HOLD) || (state == `LDMA_ST_HOLD_MEM)
                               || (state == `LDMA_ST_LAN_OWN);
      // Select never asserted while hold grant is up
      lan_ctrl_select_n_out <= !(state == `LDMA_ST_IO);
      memory_grant_n_out    <= !((state == `LDMA_ST_MEM) || (state == `LDMA_ST_HOLD_MEM));
      lan_mem_owner_out     <= (state == `LDMA_ST_LAN_OWN);
    end
  end

  // Ready: status and staged upper byte answer at once; others wait for grant
  // Writes there are acknowledged too, so a stray write cannot hang the bus
  assign cpu_ready_out = ((stat_acc || high_acc) && io_strobe)
                         || !memory_grant_n_out || !lan_ctrl_select_n_out;

  ////////////////////////////////////////////////////////////////////////////
  // Byte write enables for the two 8-bit RAMs
  wire cpu_we;
  wire lan_we;
  assign cpu_we = !memory_grant_n_out && !cpu_mem_wr_n_in;
  assign lan_we = lan_mem_owner_out && !lan_wr_n_in;
  assign ram_we_low_n_out  = !((cpu_we && !cpu_mem_addr_in[0]) || (lan_we && !lan_a0_in));
  assign ram_we_high_n_out = !((cpu_we && !cpu_bhe_n_in) || (lan_we && !lan_bhe_n_in));

  ////////////////////////////////////////////////////////////////////////////
  // 8-bit host byte staging
  reg [`LDMA_BYTE_BITS-1:0] upper_data_byte;
  reg [`LDMA_BYTE_BITS-1:0] upper_read_byte;
  reg                       io_wr_q;
  wire                      io_wr_now;
  assign io_wr_now = !lan_ctrl_select_n_out && !cpu_io_wr_n_in;

  always @(posedge clock_in) begin
    if (!rstn_in) begin
      upper_data_byte <= 8'h00;
      upper_read_byte <= 8'h00;
      io_wr_q         <= 1'b0;
      lan_io_wr_out   <= 1'b0;
      lan_wr_data_out <= 16'h0000;
    end else begin
      io_wr_q       <= io_wr_now;
      lan_io_wr_out <= 1'b0;
      // Upper-byte write goes to the latch only, lower completes the word
      if (host_8bit_in && io_hit && !cpu_io_wr_n_in && (io_off == `LDMA_IO_OFF_HIGH)) begin
        upper_data_byte <= cpu_data_in[7:0];
      end
      if (io_wr_now && !io_wr_q) begin
        lan_io_wr_out <= 1'b1;
        if (host_8bit_in) begin
          lan_wr_data_out <= {upper_data_byte, cpu_data_in[7:0]};
        end else begin
          lan_wr_data_out <= cpu_data_in;
        end
      end
      if (!lan_ctrl_select_n_out && !cpu_io_rd_n_in) begin
        upper_read_byte <= lan_rd_data_in[15:8];
      end
    end
  end

  // Read data mux; memory reads pass both bytes straight through
  always @(posedge clock_in) begin
    if (!rstn_in) begin
      cpu_data_out <= 16'h0000;
    end else if (stat_acc && !cpu_io_rd_n_in) begin
      cpu_data_out <= {15'h0000, dma_hold_grant_out};
    end else if (high_acc && !cpu_io_rd_n_in) begin
      cpu_data_out <= {8'h00, upper_read_byte};
    end else if (!lan_ctrl_select_n_out && host_8bit_in) begin
      cpu_data_out <= {8'h00, lan_rd_data_in[7:0]};
    end else begin
      cpu_data_out <= lan_rd_data_in;
    end
  end
endmodule // ldma_arbiter

// file: dv/ldma_arbiter_checker.sv
// Purpose: Port checks for the memory arbiter
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every arbiter instance
`include "ldma_consts.vh"
module ldma_arbiter_checker #(
  parameter ADDR_W = 20,
  parameter IOA_W  = 16
) (
  input logic              clock_in,
  input logic              rstn_in,
  input logic [ADDR_W-1:0] cpu_mem_addr_in,
  input logic [ADDR_W-1:0] mem_base_in,
  input logic              cpu_mem_rd_n_in,
  input logic              cpu_mem_wr_n_in,
  input logic              cpu_bhe_n_in,
  input logic              cpu_io_rd_n_in,
  input logic              cpu_io_wr_n_in,
  input logic              dma_hold_request_n_in,
  input logic              lan_bus_state_five_in,
  input logic              dma_hold_grant_out,
  input logic              lan_ctrl_select_n_out,
  input logic              memory_grant_n_out,
  input logic              lan_mem_owner_out,
  input logic              ram_we_high_n_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////////////////////////
  reset_idle_a: assert property ($rose(rstn_in) |-> !dma_hold_grant_out && lan_ctrl_select_n_out
    && memory_grant_n_out && !lan_mem_owner_out) else $error("outputs not idle after reset");
  hold_answer_a: assert property ((!dma_hold_request_n_in && cpu_io_rd_n_in && cpu_io_wr_n_in
    && cpu_mem_rd_n_in && cpu_mem_wr_n_in)[*8] |-> dma_hold_grant_out) else $error("hold not granted");
  hold_end_a: assert property (dma_hold_request_n_in[*7] |-> !dma_hold_grant_out)
    else $error("hold grant outlived request");
  io_blocked_a: assert property (dma_hold_grant_out |-> lan_ctrl_select_n_out)
    else $error("controller selected during hold");
  owner_hold_a: assert property (lan_mem_owner_out |-> dma_hold_grant_out && memory_grant_n_out)
    else $error("memory owner clash");
  five_divert_a: assert property ((dma_hold_grant_out && lan_bus_state_five_in
    && cpu_mem_rd_n_in && cpu_mem_wr_n_in)[*8] |-> lan_mem_owner_out) else $error("memory not diverted");
  mem_keep_a: assert property (!memory_grant_n_out && (!cpu_mem_rd_n_in || !cpu_mem_wr_n_in)
    |=> !memory_grant_n_out) else $error("memory grant dropped early");
  sel_keep_a: assert property (!lan_ctrl_select_n_out && (!cpu_io_rd_n_in || !cpu_io_wr_n_in)
    |=> !lan_ctrl_select_n_out) else $error("select dropped early");
  high_we_a: assert property (!memory_grant_n_out && !cpu_mem_wr_n_in && cpu_bhe_n_in
    |-> ram_we_high_n_out) else $error("high byte written");
  window_a: assert property ((cpu_mem_addr_in[ADDR_W-1:`LDMA_MEM_WIN_LSB]
    != mem_base_in[ADDR_W-1:`LDMA_MEM_WIN_LSB])[*8]
    |-> memory_grant_n_out) else $error("grant outside window");
endmodule // ldma_arbiter_checker

bind ldma_arbiter ldma_arbiter_checker #(.ADDR_W(ADDR_W), .IOA_W(IOA_W)) u_ldma_arbiter_checker (.*);

// file: dv/ldma_lan_model.sv
// Purpose: LAN controller side: hold request and bus state five
// Assumes: Burst starts on go_in, slow_in stretches the wait for state five
// Notes:   Read word inverts while deselected, so stale data never matches
module ldma_lan_model #(
  parameter logic [15:0] RD_WORD   = 16'hc3a5,
  parameter int          WORD_CLKS = 6
) (
  input  logic        clock_in,
  input  logic        go_in,
  input  logic        slow_in,
  input  logic        grant_in,
  input  logic        select_n_in,
  output logic        hold_n_out,
  output logic        five_out,
  output logic [15:0] rd_data_out
);
  assign rd_data_out = select_n_in ? ~RD_WORD : RD_WORD;
  initial begin
    hold_n_out = 1'b1;
    five_out = 1'b0;
    forever begin
      @(posedge clock_in);
      while (go_in !== 1'b1) @(posedge clock_in);
      hold_n_out <= 1'b0;
      for (int k = 0; k < 20 && grant_in !== 1'b1; k++) @(posedge clock_in);
      repeat (slow_in ? 12 : 2) @(posedge clock_in);
      five_out <= 1'b1;
      repeat (8 * WORD_CLKS) @(posedge clock_in);
      five_out <= 1'b0;
      hold_n_out <= 1'b1;
    end
  end
endmodule // ldma_lan_model

// file: dv/tb_ldma_arbiter.sv
// Purpose: Self-checking bench for the memory arbiter
// Assumes: Inputs change on the falling edge
// Notes:   Waits follow the three to four clock answer time
module tb_ldma_arbiter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] RD_WORD = 16'hc3a5;
  localparam logic [19:0] MBASE   = 20'h40000;
  localparam logic [15:0] IBASE   = 16'h0300;
  logic        clock_in = 0, rstn = 0, go = 0, slow = 0, h8 = 0, ok, wh, wl;
  logic        mrd_n = 1, mwr_n = 1, bhe_n = 1, ird_n = 1, iwr_n = 1;
  logic [19:0] maddr = 0;
  logic [15:0] iaddr = 0, wdata = 0, last_wr = 0, rdata, cdout, wdout, lrd;
  logic        hold_n, five, grant, sel_n, iow, rdy, mg_n, own, weh_n, wel_n, rst_a, rst_b;
  int          n_errors = 0, n_tests = 0;
  always #5 clock_in = ~clock_in;
  always @(posedge clock_in) if (iow === 1'b1) last_wr <= wdout;
  ////////////////////////////////////////////////////////////////////////////////
  ldma_arbiter u_ldma_arbiter (.clock_in(clock_in), .rstn_in(rstn), .cpu_mem_addr_in(maddr),
    .cpu_mem_rd_n_in(mrd_n), .cpu_mem_wr_n_in(mwr_n), .cpu_bhe_n_in(bhe_n), .cpu_io_addr_in(iaddr),
    .cpu_io_rd_n_in(ird_n), .cpu_io_wr_n_in(iwr_n), .cpu_data_in(wdata), .host_8bit_in(h8),
    .mem_base_in(MBASE), .io_base_in(IBASE), .cpu_data_out(cdout), .cpu_ready_out(rdy),
    .dma_hold_request_n_in(hold_n), .lan_bus_state_five_in(five), .lan_wr_n_in(1'b1),
    .lan_bhe_n_in(1'b1), .lan_a0_in(1'b0), .lan_rd_data_in(lrd), .dma_hold_grant_out(grant),
    .lan_ctrl_select_n_out(sel_n), .lan_io_wr_out(iow), .lan_wr_data_out(wdout), .lan_rst_n_out(rst_a),
    .encoder_rst_n_out(rst_b), .memory_grant_n_out(mg_n), .lan_mem_owner_out(own),
    .ram_we_high_n_out(weh_n), .ram_we_low_n_out(wel_n));
  ldma_lan_model #(.RD_WORD(RD_WORD)) u_ldma_lan_model (.clock_in(clock_in), .go_in(go),
    .slow_in(slow), .grant_in(grant), .select_n_in(sel_n), .hold_n_out(hold_n), .five_out(five),
    .rd_data_out(lrd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic io(input logic [15:0] a, input logic w, input logic [15:0] d);
    @(negedge clock_in);
    iaddr = IBASE + a;
    wdata = d;
    ird_n = w;
    iwr_n = !w;
    ok = 0;
    for (int k = 0; k < 14 && !ok; k++) begin
      @(posedge clock_in);
      ok = (rdy === 1'b1);
    end
    @(posedge clock_in);
    rdata = cdout;
    @(negedge clock_in);
    ird_n = 1;
    iwr_n = 1;
    repeat (8) @(negedge clock_in);
  endtask
  task automatic mem(input logic [19:0] a, input logic w, input logic b);
    @(negedge clock_in);
    maddr = a;
    bhe_n = b;
    mrd_n = w;
    mwr_n = !w;
    ok = 0;
    for (int k = 0; k < 14 && !ok; k++) begin
      @(posedge clock_in);
      ok = (mg_n === 1'b0);
    end
    @(negedge clock_in);
    wh = weh_n;
    wl = wel_n;
    rdata = cdout;
    mrd_n = 1;
    mwr_n = 1;
    repeat (8) @(negedge clock_in);
  endtask
  task automatic t_reset;
    repeat (8) @(negedge clock_in);
    chk(rst_a === 1'b0 && rst_b === 1'b0, "reset not passed on");
    rstn = 1;
    @(negedge clock_in);
    chk(grant === 0 && sel_n === 1 && mg_n === 1 && own === 0 && rst_a === 1, "reset state");
  endtask
  task automatic t_mem;
    mem(MBASE + 20'h01235, 1, 0); chk(ok && wh === 0 && wl === 1, "byte write");
    mem(MBASE + 20'h00010, 0, 1); chk(ok && mg_n === 1 && rdata === ~RD_WORD, "mem read");
    mem(MBASE + 20'h04000, 0, 1); chk(!ok, "grant outside window");
  endtask
  task automatic t_io;
    io(0, 1, 16'h1234); chk(ok && last_wr === 16'h1234, "io write");
    io(0, 0, 0); chk(ok && rdata === RD_WORD, "io read");
    io(16'h80, 1, 16'h4321); chk(!ok && last_wr === 16'h1234, "io outside window");
  endtask
  task automatic t_prio;
    @(negedge clock_in);
    iaddr = IBASE;
    maddr = MBASE;
    ird_n = 0;
    mrd_n = 0;
    repeat (8) @(negedge clock_in);
    chk(sel_n === 0 && mg_n === 1, "io not first");
    ird_n = 1;
    repeat (8) @(negedge clock_in);
    chk(mg_n === 0, "mem not served next");
    mrd_n = 1;
    repeat (8) @(negedge clock_in);
  endtask
  task automatic t_hold(input logic s);
    @(negedge clock_in);
    slow = s;
    go = 1;
    @(negedge clock_in);
    go = 0;
    for (int k = 0; k < 14 && grant !== 1; k++) @(negedge clock_in);
    chk(grant === 1, "no hold grant");
    io(4, 0, 0); chk(ok && rdata[0] === 1, "status bit");
    io(0, 1, 16'h7e7e); chk(!ok && last_wr !== 16'h7e7e, "io not blocked");
    for (int k = 0; k < 40 && own !== 1; k++) @(negedge clock_in);
    chk(own === 1 && mg_n === 1, "memory not diverted");
    for (int k = 0; k < 200 && grant !== 0; k++) @(negedge clock_in);
    chk(grant === 0 && hold_n === 1 && own === 0, "burst cut or hold stuck");
    io(4, 0, 0); chk(rdata[0] === 0, "status after hold");
    io(4, 1, 16'h7e7e); chk(ok, "io after poll");
    io(0, 1, 16'h6b6b); chk(ok && last_wr === 16'h6b6b, "io still blocked");
  endtask
  task automatic t_8bit;
    h8 = 1;
    io(2, 1, 16'h005a); chk(ok && last_wr === 16'h6b6b, "upper byte sent early");
    io(0, 1, 16'h003c); chk(last_wr === 16'h5a3c, "joined write");
    io(0, 0, 0); chk(rdata[7:0] === RD_WORD[7:0], "low byte");
    io(2, 0, 0); chk(rdata[7:0] === RD_WORD[15:8], "high byte");
    mem(MBASE, 0, 1); chk(ok && rdata === ~RD_WORD, "8-bit mem");
    h8 = 0;
  endtask
  task automatic results;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    t_reset;
    t_mem;
    t_io;
    t_prio;
    t_hold(0);
    t_hold(1);
    t_8bit;
    results;
  end
  // Whole run is under a thousand clocks; far beyond that means a hang
  initial begin
    #200us;
    n_errors++;
    results;
  end
endmodule // tb_ldma_arbiter
